// ---- hw/otc_pkg.sv ----
package otc_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  // silence on the received ac level longer than this flags signal loss
  localparam int LOS_TIME_NS = 100000;
  localparam int LOS_CYC = (LOS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOS_CW = 12;

  // ---------------------------------------------------------------
  // two-wire management access
  // ---------------------------------------------------------------
  localparam logic [6:0] DIAG_DEV_ADDR = 7'h51;
  localparam logic [7:0] STATUS_CONTROL_BYTE_OFS = 8'h6E;
  localparam logic [7:0] STATUS_CONTROL_BYTE_RST = 8'h00;

  // status/control byte field positions
  localparam int SCB_TX_OFF_STATE_BIT = 7;
  localparam int SCB_SOFT_TX_OFF_BIT = 6;
  localparam int SCB_TX_FAULT_BIT = 2;
  localparam int SCB_RX_LOST_BIT = 1;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [7:0] {
    OTC_IDLE  = 8'h01,
    OTC_ADDR  = 8'h02,
    OTC_ACK   = 8'h04,
    OTC_WPTR  = 8'h08,
    OTC_WDATA = 8'h10,
    OTC_RDATA = 8'h20,
    OTC_RACK  = 8'h40,
    OTC_RLOAD = 8'h80
  } otc_state_e;

  // open-drain pin carrier
  typedef struct packed {
    logic out;
    logic oe;
  } otc_od_s;

  // analog monitor flags feeding the fault logic
  typedef struct packed {
    logic power_low;
    logic power_high;
    logic eye_unsafe;
  } otc_mon_s;

endpackage

// ---- hw/otc_tx_control_status.sv ----
`timescale 1ns/1ns
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module otc_tx_control_status (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic tx_off_req,
  input wire otc_pkg::otc_mon_s mon,
  input wire logic rx_ac_transition,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic tx_fault_out,
  output logic tx_fault_oe,
  output logic receive_signal_lost_pin,
  output logic laser_enable
);
  import otc_pkg::*;

  // ---------------------------------------------------------------
  // transmit control
  // ---------------------------------------------------------------
  logic req_reg, req_next;
  logic soft_off_reg, soft_off_next;
  logic fault_reg, fault_next;
  logic laser_en_reg, laser_en_next;
  logic fault_oe_reg, fault_oe_next;
  logic fault_set;
  logic req_rise;
  logic soft_wr;
  logic [7:0] wr_byte;

  always_comb begin
    // a floating request reads high through the pull-up
    req_next = tx_off_req;
    req_rise = tx_off_req & ~req_reg;
    fault_set = mon.power_low | mon.power_high | mon.eye_unsafe;
    // set wins over the toggle that clears it
    if (fault_set) begin
      fault_next = 1'b1;
    end else if (req_rise) begin
      fault_next = 1'b0;
    end else begin
      fault_next = fault_reg;
    end
    if (soft_wr) begin
      soft_off_next = wr_byte[SCB_SOFT_TX_OFF_BIT];
    end else begin
      soft_off_next = soft_off_reg;
    end
    // eye trip gates the laser in the same cycle via fault_set
    laser_en_next = ~(tx_off_req | soft_off_reg | fault_reg | fault_set);
    fault_oe_next = ~fault_next;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      req_reg <= 1'b1;
      soft_off_reg <= 1'b0;
      fault_reg <= 1'b0;
      laser_en_reg <= 1'b0;
      fault_oe_reg <= 1'b1;
    end else begin
      req_reg <= req_next;
      soft_off_reg <= soft_off_next;
      fault_reg <= fault_next;
      laser_en_reg <= laser_en_next;
      fault_oe_reg <= fault_oe_next;
    end
  end

  // ---------------------------------------------------------------
  // receive signal-loss detector
  // ---------------------------------------------------------------
  logic [LOS_CW-1:0] quiet_cnt_reg, quiet_cnt_next;
  logic lost_reg, lost_next;

  always_comb begin
    quiet_cnt_next = quiet_cnt_reg;
    lost_next = lost_reg;
    if (rx_ac_transition) begin
      quiet_cnt_next = '0;
      lost_next = 1'b0;
    end else if (quiet_cnt_reg == LOS_CW'(LOS_CYC - 1)) begin
      lost_next = 1'b1;
    end else begin
      quiet_cnt_next = quiet_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      quiet_cnt_reg <= '0;
      lost_reg <= 1'b1;
    end else begin
      quiet_cnt_reg <= quiet_cnt_next;
      lost_reg <= lost_next;
    end
  end

  // ---------------------------------------------------------------
  // status/control byte image
  // ---------------------------------------------------------------
  logic [7:0] scb;

  always_comb begin
    scb = STATUS_CONTROL_BYTE_RST;
    scb[SCB_TX_OFF_STATE_BIT] = req_reg;
    scb[SCB_SOFT_TX_OFF_BIT] = soft_off_reg;
    scb[SCB_TX_FAULT_BIT] = fault_reg;
    scb[SCB_RX_LOST_BIT] = lost_reg;
  end

  // ---------------------------------------------------------------
  // two-wire slave
  // ---------------------------------------------------------------
  otc_state_e st_reg, st_next;
  otc_state_e ret_reg, ret_next;
  logic scl_d_reg, sda_d_reg;
  logic [7:0] sh_reg, sh_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [7:0] ptr_reg, ptr_next;
  logic oe_reg, oe_next;
  logic scl_rise, scl_fall, start_c, stop_c;
  logic [7:0] rd_byte;

  always_comb begin
    scl_rise = scl_in & ~scl_d_reg;
    scl_fall = ~scl_in & scl_d_reg;
    start_c = scl_in & scl_d_reg & sda_d_reg & ~sda_in;
    stop_c = scl_in & scl_d_reg & ~sda_d_reg & sda_in;
    // only one byte of the page is live; the rest reads zero
    rd_byte = (ptr_reg == STATUS_CONTROL_BYTE_OFS) ? scb : 8'h00;
    st_next = st_reg;
    ret_next = ret_reg;
    sh_next = sh_reg;
    cnt_next = cnt_reg;
    ptr_next = ptr_reg;
    oe_next = oe_reg;
    soft_wr = 1'b0;
    wr_byte = sh_reg;
    if (start_c) begin
      st_next = OTC_ADDR;
      cnt_next = 3'h0;
      oe_next = 1'b0;
    end else if (stop_c) begin
      st_next = OTC_IDLE;
      oe_next = 1'b0;
    end else begin
      case (st_reg)
        OTC_IDLE: begin
          oe_next = 1'b0;
        end
        OTC_ADDR: begin
          if (scl_rise) begin
            sh_next = {sh_reg[6:0], sda_in};
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == 3'h7) begin
              if (sh_reg[6:0] == DIAG_DEV_ADDR) begin
                if (sda_in) begin
                  ret_next = OTC_RLOAD;
                end else begin
                  ret_next = OTC_WPTR;
                end
                st_next = OTC_ACK;
              end else begin
                st_next = OTC_IDLE;
              end
            end
          end
        end
        OTC_ACK: begin
          // first falling edge pulls low, second releases, or on a read drives bit 7 of the byte
          if (scl_fall) begin
            if (!oe_reg) begin
              oe_next = 1'b1;
            end else begin
              oe_next = 1'b0;
              cnt_next = 3'h0;
              if (ret_reg == OTC_RLOAD) begin
                oe_next = ~rd_byte[7];
                sh_next = rd_byte;
                st_next = OTC_RDATA;
              end else begin
                st_next = ret_reg;
              end
            end
          end
        end
        OTC_WPTR: begin
          if (scl_rise) begin
            sh_next = {sh_reg[6:0], sda_in};
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == 3'h7) begin
              ptr_next = {sh_reg[6:0], sda_in};
              ret_next = OTC_WDATA;
              st_next = OTC_ACK;
            end
          end
        end
        OTC_WDATA: begin
          if (scl_rise) begin
            sh_next = {sh_reg[6:0], sda_in};
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == 3'h7) begin
              wr_byte = {sh_reg[6:0], sda_in};
              // mirrored bits ignore writes
              soft_wr = (ptr_reg == STATUS_CONTROL_BYTE_OFS);
              ptr_next = ptr_reg + 8'h01;
              ret_next = OTC_WDATA;
              st_next = OTC_ACK;
            end
          end
        end
        OTC_RDATA: begin
          if (scl_fall) begin
            if (cnt_reg == 3'h7) begin
              oe_next = 1'b0;
              ptr_next = ptr_reg + 8'h01;
              st_next = OTC_RACK;
            end else begin
              cnt_next = cnt_reg + 3'h1;
              sh_next = {sh_reg[6:0], 1'b0};
              oe_next = ~sh_reg[6];
            end
          end
        end
        OTC_RACK: begin
          if (scl_rise) begin
            if (sda_in) begin
              st_next = OTC_IDLE;
            end else begin
              st_next = OTC_RLOAD;
            end
          end
        end
        OTC_RLOAD: begin
          if (scl_fall) begin
            cnt_next = 3'h0;
            sh_next = rd_byte;
            oe_next = ~rd_byte[7];
            st_next = OTC_RDATA;
          end
        end
        default: begin
          st_next = OTC_IDLE;
          oe_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= OTC_IDLE;
      ret_reg <= OTC_IDLE;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      sh_reg <= 8'h00;
      cnt_reg <= 3'h0;
      ptr_reg <= 8'h00;
      oe_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      ret_reg <= ret_next;
      scl_d_reg <= scl_in;
      sda_d_reg <= sda_in;
      sh_reg <= sh_next;
      cnt_reg <= cnt_next;
      ptr_reg <= ptr_next;
      oe_reg <= oe_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  logic zero_reg;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      zero_reg <= 1'b0;
    end else begin
      zero_reg <= 1'b0;
    end
  end

  assign sda_out = zero_reg;
  assign sda_oe = oe_reg;
  assign tx_fault_out = zero_reg;
  assign tx_fault_oe = fault_oe_reg;
  assign receive_signal_lost_pin = lost_reg;
  assign laser_enable = laser_en_reg;

endmodule // otc_tx_control_status

// ---- testbench/otc_tx_control_status_monitor.sv ----
`timescale 1ns/1ns
// ----------------
// checker
// ----------------
module otc_tx_control_status_monitor
  import otc_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic tx_off_req,
  input wire otc_pkg::otc_mon_s mon,
  input wire logic rx_ac_transition,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic tx_fault_out,
  input wire logic tx_fault_oe,
  input wire logic receive_signal_lost_pin,
  input wire logic laser_enable
);
  logic [11:0] quiet_reg;
  logic [11:0] quiet_next;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // saturates so a long silence never wraps back to "present"
  always_comb begin
    quiet_next = quiet_reg + 12'h001;
    if (rx_ac_transition)
      quiet_next = 12'h000;
    else if (&quiet_reg)
      quiet_next = quiet_reg;
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      quiet_reg <= 12'hFFF;
    else
      quiet_reg <= quiet_next;
  end
  pin_off_a: assert property (tx_off_req |=> !laser_enable)
    else $error("laser on after transmit-off request");
  fault_set_a: assert property (mon != 3'h0 |=> !tx_fault_oe && !laser_enable)
    else $error("monitor flag did not raise fault");
  fault_hold_a: assert property (!tx_fault_oe && !tx_off_req |=> !tx_fault_oe)
    else $error("fault released without toggle");
  fault_clear_a: assert property (($rose(tx_off_req) && mon == 3'h0) ##1 mon == 3'h0
    |-> ##[0:1] tx_fault_oe) else $error("toggle did not clear fault");
  laser_fault_a: assert property (!tx_fault_oe |-> !laser_enable)
    else $error("laser on during fault");
  los_quiet_a: assert property (quiet_reg <= LOS_CYC - 2 |-> !receive_signal_lost_pin)
    else $error("signal lost while transitions present");
  los_lost_a: assert property (quiet_reg >= LOS_CYC + 2 |-> receive_signal_lost_pin)
    else $error("signal lost not flagged");
  pins_low_a: assert property (!sda_out && !tx_fault_out)
    else $error("open-drain output driven high");
endmodule // otc_tx_control_status_monitor

bind otc_tx_control_status otc_tx_control_status_monitor chk_u (
  .clock(clock), .arst_n(arst_n), .tx_off_req(tx_off_req), .mon(mon),
  .rx_ac_transition(rx_ac_transition), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .tx_fault_out(tx_fault_out),
  .tx_fault_oe(tx_fault_oe), .receive_signal_lost_pin(receive_signal_lost_pin),
  .laser_enable(laser_enable)
);

// ---- testbench/otc_host.sv ----
`timescale 1ns/1ns
// ----------------
// host board
// ----------------
module otc_host (
  input wire logic clock,
  input wire logic sda_oe,
  input wire logic tx_fault_oe,
  output logic scl_in,
  output logic sda_in,
  output logic fault_wire
);
  logic scl_drv = 1'h1;
  logic sda_drv = 1'h1;
  // host pull-ups: a released line reads high
  assign scl_in = scl_drv;
  assign sda_in = sda_drv & ~sda_oe;
  assign fault_wire = ~tx_fault_oe;
  task automatic hold(input logic c, input logic d);
    @(negedge clock);
    scl_drv = c;
    sda_drv = d;
    repeat (3) @(negedge clock);
  endtask
  task automatic start;
    hold(1'h0, 1'h1);
    hold(1'h1, 1'h1);
    hold(1'h1, 1'h0);
  endtask
  task automatic stop;
    hold(1'h0, 1'h0);
    hold(1'h1, 1'h0);
    hold(1'h1, 1'h1);
  endtask
  // ninth bit sent as 1 releases the line for the slave's answer
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic nak);
    for (int i = 7; i >= -1; i--) begin
      hold(1'h0, (i < 0) ? 1'h1 : d[i]);
      hold(1'h1, (i < 0) ? 1'h1 : d[i]);
      if (i < 0)
        nak = sda_in;
      else
        q[i] = sda_in;
    end
  endtask
  task automatic wr(input logic [7:0] dev, input logic [7:0] ofs, input logic [7:0] v,
                    output logic nak);
    logic [7:0] q;
    logic n0;
    logic n1;
    logic n2;
    start;
    xfer(dev, q, n0);
    xfer(ofs, q, n1);
    xfer(v, q, n2);
    stop;
    nak = n0 | n1 | n2;
  endtask
  task automatic rd(input logic [7:0] ofs, output logic [7:0] v);
    logic [7:0] q;
    logic n;
    start;
    xfer(8'hA2, q, n);
    xfer(ofs, q, n);
    start;
    xfer(8'hA3, q, n);
    xfer(8'hFF, v, n);
    stop;
  endtask
endmodule // otc_host

// ---- testbench/otc_tx_control_status_tb.sv ----
`timescale 1ns/1ns
// ----------------
// bench
// ----------------
module otc_tx_control_status_tb;
  import otc_pkg::*;
  logic clock = 1'h0;
  logic arst_n = 1'h0;
  logic tx_off_req = 1'h1;
  otc_mon_s mon = 3'h0;
  logic rx_ac_transition = 1'h0;
  logic rx_on = 1'h0;
  logic scl_in;
  logic sda_in;
  logic sda_oe;
  logic tx_fault_oe;
  logic lost_pin;
  logic laser_enable;
  logic fault_wire;
  logic nak;
  int err_count = 0;
  int cmp_count = 0;
  otc_tx_control_status dut_u (.clock(clock), .arst_n(arst_n), .tx_off_req(tx_off_req),
    .mon(mon), .rx_ac_transition(rx_ac_transition), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(), .sda_oe(sda_oe), .tx_fault_out(), .tx_fault_oe(tx_fault_oe),
    .receive_signal_lost_pin(lost_pin), .laser_enable(laser_enable));
  otc_host host_u (.clock(clock), .sda_oe(sda_oe), .tx_fault_oe(tx_fault_oe),
    .scl_in(scl_in), .sda_in(sda_in), .fault_wire(fault_wire));
  initial begin
    forever #20 clock = ~clock;
  end
  always @(negedge clock) begin
    rx_ac_transition <= rx_on & ~rx_ac_transition;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic rd_chk(input logic [7:0] exp);
    logic [7:0] v;
    host_u.rd(STATUS_CONTROL_BYTE_OFS, v);
    check(v, exp);
  endtask
  initial begin
    ticks(3);
    arst_n = 1'h1;
    ticks(2);
    check(8'(laser_enable), 8'h00);
    rd_chk(8'h82);
    rx_on = 1'h1;
    tx_off_req = 1'h0;
    ticks(4);
    check(8'(laser_enable), 8'h01);
    check(8'(lost_pin), 8'h00);
    host_u.wr(8'hA2, STATUS_CONTROL_BYTE_OFS, 8'hFF, nak);
    check(8'(nak), 8'h00);
    check(8'(laser_enable), 8'h00);
    rd_chk(8'h40);
    host_u.wr(8'hA4, STATUS_CONTROL_BYTE_OFS, 8'h00, nak);
    check(8'(nak), 8'h01);
    rd_chk(8'h40);
    arst_n = 1'h0;
    ticks(2);
    arst_n = 1'h1;
    ticks(4);
    host_u.wr(8'hA2, 8'h6D, 8'h40, nak);
    check(8'(nak), 8'h00);
    check(8'(laser_enable), 8'h01);
    rd_chk(8'h00);
    for (int i = 0; i < 3; i++) begin
      mon = otc_mon_s'(3'h4 >> i);
      ticks(1);
      mon = 3'h0;
      ticks(8);
      check(8'(fault_wire), 8'h01);
      check(8'(laser_enable), 8'h00);
      if (i == 0)
        rd_chk(8'h04);
      tx_off_req = 1'h1;
      ticks(4);
      tx_off_req = 1'h0;
      ticks(4);
      check(8'(fault_wire), 8'h00);
      check(8'(laser_enable), 8'h01);
    end
    rx_on = 1'h0;
    ticks(2600);
    check(8'(lost_pin), 8'h01);
    rd_chk(8'h02);
    rx_on = 1'h1;
    ticks(3);
    check(8'(lost_pin), 8'h00);
    test_done;
  end
  // generous over the roughly 5300 cycles the sequence needs
  initial begin
    ticks(20000);
    err_count++;
    test_done;
  end
endmodule // otc_tx_control_status_tb
